// ### core/ipt_down_timer.sv
// prescaled 8-bit down counter with selectable clock source
`timescale 1ns/100ps
module ipt_down_timer (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // control link
  ipt_tmr_if.tmr tif
);
  import ipt_pkg::*;
  logic [6:0] pre_ff;
  logic [7:0] cnt_ff;
  logic zero_ff;
  logic tick;
  logic pdone;
  logic [6:0] msk;

  // source tick selection and prescaler tap
  always_comb begin
    unique case (tif.src)
      SRC_E: tick = 1'b1;
      SRC_GATED: tick = tif.ev_level;
      SRC_STOP: tick = 1'b0;
      SRC_EVENT: tick = tif.ev_fall;
    endcase
    msk = 7'((8'h01 << tif.div) - 8'h01);
    pdone = tick && ((pre_ff & msk) == 7'h00);
  end

  // prescaler, reinitialised on request
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_ff <= PRE_RST;
    end else if (tif.pre_init) begin
      pre_ff <= PRE_RST;
    end else if (tick) begin
      pre_ff <= pre_ff - 7'h01;
    end
  end

  // counter: load wins, otherwise count down and wrap through zero
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_ff <= CNT_RST;
      zero_ff <= 1'b0;
    end else begin
      zero_ff <= !tif.load && pdone && (cnt_ff == 8'h01);
      if (tif.load) begin
        cnt_ff <= tif.load_val;
      end else if (pdone) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
  assign tif.count = cnt_ff;
  assign tif.zero = zero_ff;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_count_wraps: assert property (!tif.load && pdone && cnt_ff == 8'h00
    |=> cnt_ff == 8'hFF) else $error("counter did not wrap");
  a_stop_holds: assert property (tif.src == SRC_STOP && !tif.load
    |=> $stable(cnt_ff)) else $error("stopped counter moved");
endmodule

// ### core/ipt_irq_ctrl.sv
// interrupt priority, entry/return sequencer and register file
//
// Function
// - entry pushes pc low, pc high, x, a, flags
// - stack pointer top on reset, moves per byte
// - set mask flag, then fetch source vector
// - return pulls status, resumes next instruction
// - fixed priority: reset, trap, ext one, pairs
// - timer/ext two and serial/tick share vectors
// - mask latches requests; wait one instruction after clear
// - held requests serviced one at a time
// - both request pins latch on falling edge
// - ext one latch clears on vectoring
// - ext two edge sets misc bit 7
// - misc bit 7 cleared by zero only
// - misc bit 6 masks ext two; reset sets it
// - timer, serial, tick individual mask bits
// - pin levels read directly for branch tests
// - counter loads, counts down, zero sets flag
// - clock from event pin or gated E
// - counter wraps to all ones, reads live
// - reset: prescaler, counter ones; flag clear, mask set
// - timer flag held until zero written
// - control bits 5:4 choose clock source
// - control bits 2:0 pick division; bit 3 reinitialises
`timescale 1ns/100ps
module ipt_irq_ctrl (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // avalon-mm register slave
  input wire logic [ipt_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // request pins and on-chip sources
  input wire logic ext_req_one_pin_n_in,
  input wire logic ext_req_two_pin_n_in,
  input wire logic count_event_pin_in,
  input wire logic serial_done_in,
  input wire logic rate_tick_source_in,
  // sequencer handshake
  input wire logic insn_boundary_in,
  input wire logic soft_trap_in,
  input wire logic trap_return_op_in,
  input wire logic mask_clear_op_in,
  input wire logic mask_set_op_in,
  input wire logic stack_reinit_op_in,
  input wire logic [13:0] pc_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] accum_in,
  input wire logic [4:0] cpu_flag_reg_in,
  output logic seq_busy_out,
  output logic mask_flag_out,
  output logic [13:0] stack_ptr_out,
  output logic pc_load_out,
  output logic [13:0] pc_value_out,
  output logic restore_out,
  output logic [7:0] restore_index_out,
  output logic [7:0] restore_accum_out,
  output logic [4:0] restore_flags_out,
  // stack and vector memory port
  output logic [13:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  // pin levels for branch tests
  output logic ext_one_level_out,
  output logic ext_two_level_out
);
  import ipt_pkg::*;

  ipt_tmr_if tif();
  ipt_seq_t state_ff;
  logic [PIN_COUNT-1:0] pin_lvl;
  logic [PIN_COUNT-1:0] pin_fall;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [IDX_W-1:0] idx;
  logic wr_ok;
  logic [7:0] wd;
  logic ext1_ff, ext2_ff, ext2_mask_ff;
  logic tflag_ff, tmask_ff;
  logic [1:0] src_ff;
  logic [2:0] div_ff;
  logic sflag_ff, rflag_ff, smask_ff, rmask_ff;
  logic i_ff, hold_ff;
  logic lvl1_ff, lvl2_ff;
  logic [2:0] step_ff;
  logic [13:0] sp_ff, vec_ff, addr_ff, pcv_ff;
  logic [7:0] wdat_ff, hi_ff;
  logic [7:0] stk_ff [5];
  logic rd_ff, wr_ff, pcl_ff, rst_ff, busy_ff;
  logic take, clr1, ret_go, idle, p_tv, p_sv;
  logic [13:0] take_vec;

  // pin synchronisers and edge detectors
  ipt_pin_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pins_in({count_event_pin_in, ext_req_two_pin_n_in,
      ext_req_one_pin_n_in}),
    .level_out(pin_lvl),
    .fall_out(pin_fall)
  );

  // down counter
  ipt_down_timer u_tmr (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .tif(tif.tmr)
  );

  // bus decode: one wait cycle, then accept
  assign idx = avs_address_in[ADDR_W-1:2];
  assign wd = avs_writedata_in[7:0];
  assign wr_ok = avs_write_in && !wait_ff && avs_byteenable_in[0];

  // waitrequest drops for one cycle per request; read data registered
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= !((avs_read_in || avs_write_in) && wait_ff);
      unique case (idx)
        IDX_COUNT: rdata_ff <= {24'h000000, tif.count};
        IDX_CTRL: rdata_ff <= {24'h000000, tflag_ff, tmask_ff, src_ff,
          1'b0, div_ff};
        IDX_MISC: rdata_ff <= {24'h000000, ext2_ff, ext2_mask_ff, 6'h00};
        IDX_SERIAL: rdata_ff <= {24'h000000, sflag_ff, rflag_ff, smask_ff,
          rmask_ff, 4'h0};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // timer control from software writes, event pin level and edge from the synchronisers
  assign tif.load = wr_ok && idx == IDX_COUNT;
  assign tif.load_val = wd;
  assign tif.src = src_ff;
  assign tif.div = div_ff;
  assign tif.pre_init = wr_ok && idx == IDX_CTRL && wd[PRE_INIT_BIT];
  assign tif.ev_level = pin_lvl[2];
  assign tif.ev_fall = pin_fall[2];

  // control and mask fields
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tmask_ff <= CTRL_RST[MASK_BIT];
      src_ff <= CTRL_RST[SRC_HI:SRC_LO];
      div_ff <= CTRL_RST[2:0];
      ext2_mask_ff <= MISC_RST[MASK_BIT];
      smask_ff <= SER_RST[SER_MASK_BIT];
      rmask_ff <= SER_RST[RATE_MASK_BIT];
    end else if (wr_ok) begin
      if (idx == IDX_CTRL) begin
        tmask_ff <= wd[MASK_BIT];
        src_ff <= wd[SRC_HI:SRC_LO];
        div_ff <= wd[2:0];
      end
      if (idx == IDX_MISC) begin
        ext2_mask_ff <= wd[MASK_BIT];
      end
      if (idx == IDX_SERIAL) begin
        smask_ff <= wd[SER_MASK_BIT];
        rmask_ff <= wd[RATE_MASK_BIT];
      end
    end
  end

  // request flags: hardware set wins, software may only write zero
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ext2_ff <= 1'b0;
      tflag_ff <= 1'b0;
      sflag_ff <= 1'b0;
      rflag_ff <= 1'b0;
    end else begin
      if (pin_fall[1]) begin
        ext2_ff <= 1'b1;
      end else if (wr_ok && idx == IDX_MISC && !wd[FLAG_BIT]) begin
        ext2_ff <= 1'b0;
      end
      if (tif.zero) begin
        tflag_ff <= 1'b1;
      end else if (wr_ok && idx == IDX_CTRL && !wd[FLAG_BIT]) begin
        tflag_ff <= 1'b0;
      end
      if (serial_done_in) begin
        sflag_ff <= 1'b1;
      end else if (wr_ok && idx == IDX_SERIAL && !wd[SER_FLAG_BIT]) begin
        sflag_ff <= 1'b0;
      end
      if (rate_tick_source_in) begin
        rflag_ff <= 1'b1;
      end else if (wr_ok && idx == IDX_SERIAL && !wd[RATE_FLAG_BIT]) begin
        rflag_ff <= 1'b0;
      end
    end
  end

  // first external request latch, cleared when its vector is taken
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ext1_ff <= 1'b0;
    end else if (pin_fall[0]) begin
      ext1_ff <= 1'b1;
    end else if (clr1) begin
      ext1_ff <= 1'b0;
    end
  end

  // pin levels for the branch tests, independent of the latches
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lvl1_ff <= 1'b1;
      lvl2_ff <= 1'b1;
    end else begin
      lvl1_ff <= pin_lvl[0];
      lvl2_ff <= pin_lvl[1];
    end
  end

  // priority resolution at instruction boundaries
  assign idle = state_ff == ipt_idle;
  assign p_tv = (tflag_ff && !tmask_ff) || (ext2_ff && !ext2_mask_ff);
  assign p_sv = (sflag_ff && !smask_ff) || (rflag_ff && !rmask_ff);
  always_comb begin
    take = 1'b0;
    clr1 = 1'b0;
    take_vec = VEC_SER;
    if (idle && insn_boundary_in) begin
      if (soft_trap_in) begin
        take = 1'b1;
        take_vec = VEC_SOFT;
      end else if (!i_ff && !hold_ff && !mask_clear_op_in) begin
        if (ext1_ff) begin
          take = 1'b1;
          clr1 = 1'b1;
          take_vec = VEC_EXT1;
        end else if (p_tv) begin
          take = 1'b1;
          take_vec = VEC_TMR;
        end else if (p_sv) begin
          take = 1'b1;
          take_vec = VEC_SER;
        end
      end
    end
  end
  assign ret_go = idle && trap_return_op_in && !take;

  // mask flag and the one-instruction hold after a mask clear
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      i_ff <= 1'b1;
      hold_ff <= 1'b0;
    end else begin
      if (mask_clear_op_in) begin
        hold_ff <= 1'b1;
      end else if (insn_boundary_in) begin
        hold_ff <= 1'b0;
      end
      if (state_ff == ipt_push && step_ff == PUSH_LAST) begin
        i_ff <= 1'b1;
      end else if (state_ff == ipt_pull_end) begin
        i_ff <= stk_ff[4][CC_I_BIT];
      end else if (idle && mask_set_op_in) begin
        i_ff <= 1'b1;
      end else if (idle && mask_clear_op_in) begin
        i_ff <= 1'b0;
      end
    end
  end

  // entry and return sequencer with stack pointer
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= ipt_boot;
      step_ff <= 3'h0;
      sp_ff <= SP_TOP;
      vec_ff <= VEC_RESET;
      addr_ff <= 14'h0000;
      wdat_ff <= 8'h00;
      hi_ff <= 8'h00;
      pcv_ff <= 14'h0000;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      pcl_ff <= 1'b0;
      rst_ff <= 1'b0;
      busy_ff <= 1'b1;
      for (int k = 0; k < 5; k++) begin
        stk_ff[k] <= 8'h00;
      end
    end else begin
      pcl_ff <= 1'b0;
      rst_ff <= 1'b0;
      unique case (state_ff)
        ipt_boot: begin
          rd_ff <= 1'b1;
          addr_ff <= vec_ff;
          state_ff <= ipt_vec_hi;
        end
        ipt_idle: begin
          if (take) begin
            stk_ff[0] <= pc_in[7:0];
            stk_ff[1] <= {2'h0, pc_in[13:8]};
            stk_ff[2] <= index_in;
            stk_ff[3] <= accum_in;
            stk_ff[4] <= {3'h0, cpu_flag_reg_in};
            vec_ff <= take_vec;
            wr_ff <= 1'b1;
            addr_ff <= sp_ff;
            wdat_ff <= pc_in[7:0];
            sp_ff <= sp_ff - 14'h0001;
            step_ff <= 3'h1;
            busy_ff <= 1'b1;
            state_ff <= ipt_push;
          end else if (ret_go) begin
            rd_ff <= 1'b1;
            addr_ff <= sp_ff + 14'h0001;
            sp_ff <= sp_ff + 14'h0001;
            step_ff <= 3'h0;
            busy_ff <= 1'b1;
            state_ff <= ipt_pull;
          end else if (stack_reinit_op_in) begin
            sp_ff <= SP_TOP;
          end
        end
        ipt_push: begin
          if (step_ff == PUSH_LAST) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b1;
            addr_ff <= vec_ff;
            state_ff <= ipt_vec_hi;
          end else begin
            addr_ff <= sp_ff;
            wdat_ff <= stk_ff[step_ff];
            sp_ff <= sp_ff - 14'h0001;
            step_ff <= step_ff + 3'h1;
          end
        end
        ipt_vec_hi: begin
          addr_ff <= vec_ff + 14'h0001;
          state_ff <= ipt_vec_lo;
        end
        ipt_vec_lo: begin
          rd_ff <= 1'b0;
          hi_ff <= mem_rdata_in;
          state_ff <= ipt_vec_done;
        end
        ipt_vec_done: begin
          pcv_ff <= {hi_ff[5:0], mem_rdata_in};
          pcl_ff <= 1'b1;
          busy_ff <= 1'b0;
          state_ff <= ipt_idle;
        end
        ipt_pull: begin
          if (step_ff != 3'h0) begin
            stk_ff[3'(PUSH_LAST - step_ff)] <= mem_rdata_in;
          end
          if (step_ff == PULL_LAST) begin
            rd_ff <= 1'b0;
            state_ff <= ipt_pull_end;
          end else begin
            addr_ff <= sp_ff + 14'h0001;
            sp_ff <= sp_ff + 14'h0001;
            step_ff <= step_ff + 3'h1;
          end
        end
        ipt_pull_end: begin
          stk_ff[0] <= mem_rdata_in;
          pcv_ff <= {stk_ff[1][5:0], mem_rdata_in};
          pcl_ff <= 1'b1;
          rst_ff <= 1'b1;
          busy_ff <= 1'b0;
          state_ff <= ipt_idle;
        end
      endcase
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata_out = rdata_ff;
  assign avs_waitrequest_out = wait_ff;
  assign seq_busy_out = busy_ff;
  assign mask_flag_out = i_ff;
  assign stack_ptr_out = sp_ff;
  assign pc_load_out = pcl_ff;
  assign pc_value_out = pcv_ff;
  assign restore_out = rst_ff;
  assign restore_index_out = stk_ff[2];
  assign restore_accum_out = stk_ff[3];
  assign restore_flags_out = stk_ff[4][4:0];
  assign mem_addr_out = addr_ff;
  assign mem_rd_out = rd_ff;
  assign mem_wr_out = wr_ff;
  assign mem_wdata_out = wdat_ff;
  assign ext_one_level_out = lvl1_ff;
  assign ext_two_level_out = lvl2_ff;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_entry;
    take;
  endsequence
  sequence s_push_bytes;
    mem_wr_out && mem_wdata_out == $past(pc_in[7:0])
    ##1 mem_wr_out && mem_wdata_out == {2'h0, $past(pc_in[13:8], 2)}
    ##1 mem_wdata_out == $past(index_in, 3)
    ##1 mem_wdata_out == $past(accum_in, 4);
  endsequence
  a_push_order: assert property (s_entry |=> s_push_bytes)
    else $error("stacking order wrong");
  a_sp_follows: assert property (mem_wr_out
    |-> stack_ptr_out == mem_addr_out - 14'h0001)
    else $error("stack pointer not decremented");
  a_sp_reinit: assert property (idle && !take && !ret_go
    && stack_reinit_op_in |=> stack_ptr_out == SP_TOP)
    else $error("stack pointer not reset");
  a_mask_first: assert property ($rose(mem_rd_out) && !mem_wr_out
    && state_ff == ipt_vec_hi |-> mask_flag_out)
    else $error("vector fetched with mask clear");
  a_return_len: assert property (ret_go |-> ##7 restore_out && pc_load_out)
    else $error("return sequence length wrong");
  a_soft_vector: assert property (take && soft_trap_in
    |=> vec_ff == VEC_SOFT) else $error("trap vector wrong");
  a_masked_wait: assert property (idle && insn_boundary_in && i_ff
    && !soft_trap_in |-> !take) else $error("masked request taken");
  a_clear_delay: assert property (mask_clear_op_in |-> !take)
    else $error("taken in clearing cycle");
  a_ext1_clear: assert property (clr1 && !pin_fall[0] |=> !ext1_ff)
    else $error("ext one latch kept");
  a_ext2_set: assert property (pin_fall[1] |=> ext2_ff)
    else $error("ext two flag not set");
  a_ext2_nosw: assert property (!ext2_ff && !pin_fall[1] |=> !ext2_ff)
    else $error("ext two flag set by software");
  a_tflag_hold: assert property (tflag_ff && !(wr_ok && idx == IDX_CTRL
    && !wd[FLAG_BIT]) |=> tflag_ff)
    else $error("timer flag lost");
endmodule

// ### core/ipt_pin_sync.sv
// two-stage synchronisers and falling-edge detectors for the request pins and the event pin
`timescale 1ns/100ps
module ipt_pin_sync (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // raw pins and their synchronised views
  input wire logic [ipt_pkg::PIN_COUNT-1:0] pins_in,
  output logic [ipt_pkg::PIN_COUNT-1:0] level_out,
  output logic [ipt_pkg::PIN_COUNT-1:0] fall_out
);
  import ipt_pkg::*;
  logic [PIN_COUNT-1:0] meta_ff;
  logic [PIN_COUNT-1:0] sync_ff;
  logic [PIN_COUNT-1:0] prev_ff;

  // per pin: first stage feeds only the second, edge seen on later stages;
  // reset to each pin's idle level so no false edge or tick follows reset
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
        meta_ff[g] <= PIN_RST[g];
        sync_ff[g] <= PIN_RST[g];
        prev_ff[g] <= PIN_RST[g];
      end else begin
        meta_ff[g] <= pins_in[g];
        sync_ff[g] <= meta_ff[g];
        prev_ff[g] <= sync_ff[g];
      end
    end
    assign level_out[g] = sync_ff[g];
    assign fall_out[g] = prev_ff[g] & ~sync_ff[g];
  end
endmodule

// ### core/ipt_pkg.sv
// constants, register map and state type of the interrupt and timer block
package ipt_pkg;
  // register indices; byte address is four times the index
  localparam int IDX_W = 5;
  localparam logic [IDX_W-1:0] IDX_COUNT = 5'h08;
  localparam logic [IDX_W-1:0] IDX_CTRL = 5'h09;
  localparam logic [IDX_W-1:0] IDX_MISC = 5'h0A;
  localparam logic [IDX_W-1:0] IDX_SERIAL = 5'h11;
  localparam int ADDR_W = 7;
  // values after reset
  localparam logic [7:0] MISC_RST = 8'h40;
  localparam logic [7:0] CTRL_RST = 8'h50;
  localparam logic [7:0] SER_RST = 8'h30;
  localparam logic [7:0] CNT_RST = 8'hFF;
  localparam logic [6:0] PRE_RST = 7'h7F;
  // field positions
  localparam int FLAG_BIT = 7;
  localparam int MASK_BIT = 6;
  localparam int SRC_HI = 5;
  localparam int SRC_LO = 4;
  localparam int PRE_INIT_BIT = 3;
  localparam int SER_FLAG_BIT = 7;
  localparam int RATE_FLAG_BIT = 6;
  localparam int SER_MASK_BIT = 5;
  localparam int RATE_MASK_BIT = 4;
  localparam int CC_I_BIT = 3;
  // clock source codes of the down counter
  localparam logic [1:0] SRC_E = 2'h0;
  localparam logic [1:0] SRC_GATED = 2'h1;
  localparam logic [1:0] SRC_STOP = 2'h2;
  localparam logic [1:0] SRC_EVENT = 2'h3;
  // stack limits and vector addresses
  localparam logic [13:0] SP_TOP = 14'h00FF;
  localparam logic [13:0] SP_LOW = 14'h00C1;
  localparam logic [13:0] VEC_RESET = 14'h1FFE;
  localparam logic [13:0] VEC_SOFT = 14'h1FFC;
  localparam logic [13:0] VEC_EXT1 = 14'h1FFA;
  localparam logic [13:0] VEC_TMR = 14'h1FF8;
  localparam logic [13:0] VEC_SER = 14'h1FF6;
  // bytes saved on entry and pins synchronised
  localparam logic [2:0] PUSH_LAST = 3'h5;
  localparam logic [2:0] PULL_LAST = 3'h4;
  localparam int PIN_COUNT = 3;
  // synchroniser reset levels: request pins idle high, event pin idles low
  localparam logic [PIN_COUNT-1:0] PIN_RST = 3'h3;
  // entry and return sequencer states
  typedef enum logic [2:0] {
    ipt_boot, ipt_idle, ipt_push, ipt_vec_hi, ipt_vec_lo, ipt_vec_done,
    ipt_pull, ipt_pull_end
  } ipt_seq_t;
endpackage

// ### core/ipt_tmr_if.sv
// link between the control logic and the down counter
`timescale 1ns/100ps
interface ipt_tmr_if;
  logic load;
  logic [7:0] load_val;
  logic [1:0] src;
  logic [2:0] div;
  logic pre_init;
  logic ev_level;
  logic ev_fall;
  logic [7:0] count;
  logic zero;
  modport ctl (output load, load_val, src, div, pre_init, ev_level,
    ev_fall, input count, zero);
  modport tmr (input load, load_val, src, div, pre_init, ev_level,
    ev_fall, output count, zero);
endinterface

// ### testbench/ipt_mem_model.sv
// stack and vector memory model answering one cycle after each read
`timescale 1ns/100ps
module ipt_mem_model (
  // clock
  input wire logic sys_clk_in,
  // memory port of the block
  input wire logic [13:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] ram [256];
  initial rdata_out = 8'h00;
  // vectors return their own low address byte; idle data keeps toggling
  always @(posedge sys_clk_in) begin
    if (wr_in) ram[addr_in[7:0]] <= wdata_in;
    if (!rd_in) rdata_out <= ~rdata_out;
    else if (addr_in[13:8] == 6'h1F) rdata_out <= addr_in[7:0];
    else rdata_out <= ram[addr_in[7:0]];
  end
endmodule

// ### testbench/testbench.sv
// self-checking bench of the interrupt and down timer block
`timescale 1ns/100ps
module testbench;
  import ipt_pkg::*;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, rd = 1'b0, wr = 1'b0;
  logic e1 = 1'b1, e2 = 1'b1, bnd = 1'b0, trap = 1'b0, ret = 1'b0;
  logic clr = 1'b0, rsp = 1'b0, wt, busy, msk, pc_low_byte, rst, mr, mw, l1, l2;
  logic ev = 1'b0, sdn = 1'b0, tck = 1'b0, mset = 1'b0;
  logic [6:0] adr = 7'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [7:0] q, rx, ra, mwd, mrd;
  logic [4:0] rf;
  logic [13:0] sp, pcv, ma;
  int n_fail = 0, checked = 0;
  // clock and watchdog
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
  ipt_irq_ctrl DUT (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt),
    .ext_req_one_pin_n_in(e1), .ext_req_two_pin_n_in(e2),
    .count_event_pin_in(ev), .serial_done_in(sdn),
    .rate_tick_source_in(tck), .insn_boundary_in(bnd),
    .soft_trap_in(trap), .trap_return_op_in(ret), .mask_clear_op_in(clr),
    .mask_set_op_in(mset), .stack_reinit_op_in(rsp), .pc_in(14'h0123),
    .index_in(8'h5A), .accum_in(8'hA5), .cpu_flag_reg_in(5'h00),
    .seq_busy_out(busy), .mask_flag_out(msk), .stack_ptr_out(sp),
    .pc_load_out(pc_low_byte), .pc_value_out(pcv), .restore_out(rst),
    .restore_index_out(rx), .restore_accum_out(ra),
    .restore_flags_out(rf), .mem_addr_out(ma), .mem_rd_out(mr),
    .mem_wr_out(mw), .mem_wdata_out(mwd), .mem_rdata_in(mrd),
    .ext_one_level_out(l1), .ext_two_level_out(l2));
  ipt_mem_model MEM (.sys_clk_in(sys_clk_in), .addr_in(ma), .rd_in(mr),
    .wr_in(mw), .wdata_in(mwd), .rdata_out(mrd));
  task automatic chk(input logic [15:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask
  // one register access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] i,
    input logic [7:0] d);
    @(posedge sys_clk_in);
    adr <= {i, 2'b00};
    wd <= {24'h0, d};
    rd <= !w;
    wr <= w;
    // no local limit: only the watchdog ends a wait with no answer
    @(posedge sys_clk_in);
    while (wt !== 1'b0) @(posedge sys_clk_in);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // boundaries every cycle until the vector is loaded
  task automatic enter(input logic t, input logic [13:0] v);
    @(posedge sys_clk_in);
    bnd <= 1'b1;
    trap <= t;
    @(posedge sys_clk_in);
    trap <= 1'b0;
    while (pc_low_byte !== 1'b1) @(posedge sys_clk_in);
    bnd <= 1'b0;
    chk(pcv, v, "vector");
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset values and the block's own reset vector fetch
  task automatic test_reset;
    while (pc_low_byte !== 1'b1) @(posedge sys_clk_in);
    chk(pcv, 14'h3EFF, "reset vector");
    bus(0, IDX_COUNT, 8'h00);
    chk(q, 8'hFF, "count reset");
    bus(0, IDX_CTRL, 8'h00);
    chk(q, 8'h50, "ctrl reset");
    bus(0, IDX_MISC, 8'h00);
    chk(q, 8'h40, "misc reset");
    bus(0, 5'h1F, 8'h00);
    chk(q, 8'h00, "unmapped");
    $display("test reset done");
  endtask
  // pin requests held under the mask, entry, return, second source
  task automatic test_entry;
    bus(1, IDX_MISC, 8'h80);
    bus(0, IDX_MISC, 8'h00);
    chk(q, 8'h00, "ext two not set by write");
    @(posedge sys_clk_in);
    e2 <= 1'b0;
    e1 <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    chk(l1, 1'b0, "pin level");
    bus(1, IDX_MISC, 8'h80);
    bus(0, IDX_MISC, 8'h00);
    chk(q, 8'h80, "ext two flag");
    @(posedge sys_clk_in);
    bnd <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    bnd <= 1'b0;
    @(posedge sys_clk_in);
    chk(busy, 1'b0, "masked held");
    @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    enter(0, 14'h3AFB);
    chk(sp, 14'h00FA, "sp after push");
    chk(msk, 1'b1, "mask set");
    chk({MEM.ram[8'hFF], MEM.ram[8'hFE]}, 16'h2301, "pc pushed");
    chk({MEM.ram[8'hFD], MEM.ram[8'hFC]}, 16'h5AA5, "x a pushed");
    chk(MEM.ram[8'hFB], 8'h00, "flags pushed");
    @(posedge sys_clk_in);
    ret <= 1'b1;
    @(posedge sys_clk_in);
    ret <= 1'b0;
    while (rst !== 1'b1) @(posedge sys_clk_in);
    chk({rx, ra}, 16'h5AA5, "restored x a");
    chk(rf, 5'h00, "restored flags");
    chk(pcv, 14'h0123, "resume pc");
    chk(sp, 14'h00FF, "sp after pull");
    enter(0, 14'h38F9);
    bus(1, IDX_MISC, 8'h40);
    bus(0, IDX_MISC, 8'h00);
    chk(q, 8'h40, "ext two clear");
    $display("test entry done");
  endtask
  // software trap under the mask, then stack pointer reinit
  task automatic test_trap;
    enter(1, 14'h3CFD);
    @(posedge sys_clk_in);
    rsp <= 1'b1;
    @(posedge sys_clk_in);
    rsp <= 1'b0;
    @(posedge sys_clk_in);
    chk(sp, 14'h00FF, "stack reinit");
    $display("test trap done");
  endtask
  // down counter on the internal clock reaching zero
  task automatic test_timer;
    bus(1, IDX_COUNT, 8'h03);
    bus(1, IDX_CTRL, 8'h00);
    repeat (10) @(posedge sys_clk_in);
    bus(0, IDX_CTRL, 8'h00);
    chk(q, 8'h80, "timer flag");
    bus(1, IDX_CTRL, 8'h60);
    bus(0, IDX_CTRL, 8'h00);
    chk(q, 8'h60, "flag cleared");
    $display("test timer done");
  endtask
  // serial and tick flags, their masks, mask set, ext two as plain input
  task automatic test_sources;
    @(posedge sys_clk_in);
    sdn <= 1'b1;
    tck <= 1'b1;
    @(posedge sys_clk_in);
    sdn <= 1'b0;
    tck <= 1'b0;
    bus(0, IDX_SERIAL, 8'h00);
    chk(q, 8'hF0, "serial flags");
    @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    bnd <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    bnd <= 1'b0;
    @(posedge sys_clk_in);
    chk(busy, 1'b0, "masked sources");
    mset <= 1'b1;
    @(posedge sys_clk_in);
    mset <= 1'b0;
    @(posedge sys_clk_in);
    chk(msk, 1'b1, "mask set op");
    bus(1, IDX_SERIAL, 8'h40);
    @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    enter(0, 14'h36F7);
    bus(0, IDX_SERIAL, 8'h00);
    chk(q, 8'h40, "tick flag kept");
    @(posedge sys_clk_in);
    e2 <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    e2 <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    chk(l2, 1'b0, "ext two level");
    bus(0, IDX_MISC, 8'h00);
    chk(q, 8'hC0, "masked ext two");
    $display("test sources done");
  endtask
  // event pin falling edges clock the counter
  task automatic test_event;
    bus(1, IDX_COUNT, 8'h05);
    bus(1, IDX_CTRL, 8'h70);
    repeat (3) begin
      @(posedge sys_clk_in);
      ev <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
      ev <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
    end
    bus(0, IDX_COUNT, 8'h00);
    chk(q, 8'h02, "event count");
    $display("test event done");
  endtask
  // scenarios
  initial begin
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    test_reset();
    test_entry();
    test_trap();
    test_timer();
    test_sources();
    test_event();
    print_verdict();
  end
endmodule
